// File: rtl/adcsc_fmt.sv
`timescale 1ns/100ps
`default_nettype none
module adcsc_fmt
   import adcsc_pkg::*;
#(
   parameter int WIDTH = 16
)
(
   // raw two's complement sample
   input  wire logic [WIDTH-1:0] raw,
   // 1 selects offset binary
   input  wire logic             offset,
   // formatted result
   output logic      [WIDTH-1:0] coded
);
   if (WIDTH < 2)
   begin : g_bad_width
      $error("adcsc_fmt width too small");
   end

   // offset binary is two's complement with the sign flipped
   assign coded = {raw[WIDTH-1] ^ offset, raw[WIDTH-2:0]};
endmodule : adcsc_fmt
`default_nettype wire

// File: rtl/adcsc_top.sv
// What this block does
// - unassigned i/o addresses get no acknowledge and no data drive.
// - accesses end after one wait state; mailbox read during write stretches to six.
// - mailbox one entry per channel single-ended, two entries differential.
// - high byte at even address, low byte at odd address.
// - control register takes byte and word writes, only addressed lanes change.
// - reset clears the whole control register.
// - control bit 1 picks two's complement or offset binary results.
// - control bit 2 makes trigger pin input or driven output.
// - control bits 5:3 pick differential, single-ended, calibration or auto-zero source.
// - control bits 10:8 pick scan mode.
// - control bit 11 gates the conversion interval timer.
// - control bits 13:12 pick none, per-channel or per-group interrupts.
// - unassigned control bits store and read back, no effect.
// - result codes follow two's complement or offset binary mapping.
`timescale 1ns/100ps
`default_nettype none
module adcsc_top
   import adcsc_pkg::*;
#(
   parameter int DATA_W = 16
)
(
   // clock and reset
   input  wire logic              clk,
   input  wire logic              rstn,
   // host i/o bus, synchronous to clk
   input  wire logic              io_sel_n,
   input  wire logic              write_n,
   input  wire logic [5:0]        addr,
   input  wire logic [1:0]        byte_sel_n,
   input  wire logic [15:0]       data_in,
   output logic      [15:0]       data_out,
   output logic                   data_oe,
   output logic                   ack_n,
   // conversion results from the converter sequencer
   input  wire logic              conv_valid,
   input  wire logic [4:0]        conv_chan,
   input  wire logic [DATA_W-1:0] conv_raw,
   // external trigger pin
   input  wire logic              trig_in,
   output logic                   trig_out,
   output logic                   trig_oe,
   // periodic tick from the interval timer
   input  wire logic              timer_tick,
   // decoded control towards the acquisition logic
   output logic                   fmt_offset,
   output logic [2:0]             source_sel,
   output logic                   source_diff,
   output logic                   source_calib,
   output logic [2:0]             scan_mode,
   output logic                   scan_active,
   output logic                   timer_run,
   output logic                   irq_each,
   output logic                   irq_group,
   output logic                   conv_start
);
   if (DATA_W != 16)
   begin : g_bad_width
      $error("adcsc_top supports 16-bit results only");
   end

   adcsc_bus_t        bus_state;
   logic [15:0]       ctrl;
   logic [2:0]        wait_cnt;
   logic              wr_pending;
   logic [4:0]        wr_chan;
   logic [DATA_W-1:0] wr_data;
   logic [DATA_W-1:0] coded;
   logic [DATA_W-1:0] mbox [ADCSC_CHANNELS];
   logic              trig_meta;
   logic              trig_sync;
   logic              trig_prev;
   logic              next_scan_on;
   logic              is_ctrl;
   logic              is_zero_reg;
   logic              is_mbox;
   logic              mapped;
   logic              stretch;
   logic [15:0]       rd_word;
   logic [4:0]        mb_idx;

   // address decode; the gap between start-convert and gain is not assigned
   assign is_ctrl     = (addr == ADCSC_CTRL_WADDR);
   assign is_zero_reg = ((addr >= ADCSC_RSVD_LO_WADDR) && (addr <= ADCSC_RSVD_HI_WADDR))
                     || ((addr >= ADCSC_GAIN_LO_WADDR) && (addr <= ADCSC_GAIN_HI_WADDR));
   assign is_mbox     = (addr >= ADCSC_MBOX_LO_WADDR);
   assign mapped      = is_ctrl || is_zero_reg || is_mbox;
   assign mb_idx      = addr[4:0];

   // a mailbox read waits while a fresh result is still being stored
   assign stretch = is_mbox && write_n && wr_pending
                 && (wait_cnt < ADCSC_MAX_WAIT_STATES);

   // read mux, whole word; the host picks its lane
   always_comb
   begin
      rd_word = 16'h0000;
      if (is_ctrl)
      begin
         rd_word = ctrl;
      end
      else if (is_mbox)
      begin
         rd_word = mbox[mb_idx];
      end
   end

   // bus cycle sequencer
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         bus_state <= ADCSC_IDLE;
         wait_cnt  <= 3'h0;
      end
      else
      begin
         unique case (bus_state)
            ADCSC_IDLE:
            begin
               wait_cnt <= 3'h0;
               if (!io_sel_n && mapped)
               begin
                  bus_state <= ADCSC_WAIT;
                  wait_cnt  <= ADCSC_WAIT_STATES;
               end
               else if (!io_sel_n)
               begin
                  bus_state <= ADCSC_HOLD; // silent until the host gives up
               end
            end
            ADCSC_WAIT:
            begin
               if (stretch)
               begin
                  wait_cnt <= wait_cnt + 3'h1;
               end
               else
               begin
                  bus_state <= ADCSC_ACK;
               end
            end
            ADCSC_ACK:
            begin
               bus_state <= ADCSC_HOLD;
            end
            ADCSC_HOLD:
            begin
               if (io_sel_n)
               begin
                  bus_state <= ADCSC_IDLE;
               end
            end
         endcase
      end
   end

   // acknowledge and read data drive
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ack_n    <= 1'b1;
         data_oe  <= 1'b0;
         data_out <= 16'h0000;
      end
      else
      begin
         ack_n <= 1'b1;
         if ((bus_state == ADCSC_WAIT) && !stretch)
         begin
            ack_n <= 1'b0; // one-cycle acknowledge
            if (write_n)
            begin
               data_out <= rd_word; // high byte even, low byte odd
               data_oe  <= 1'b1;
            end
         end
         else if (io_sel_n)
         begin
            data_oe <= 1'b0;
         end
      end
   end

   // control register with byte-lane writes
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         ctrl <= ADCSC_CTRL_RESET;
      end
      else if ((bus_state == ADCSC_WAIT) && !stretch && !write_n && is_ctrl)
      begin
         if (!byte_sel_n[1])
         begin
            ctrl[15:8] <= data_in[15:8]; // even byte
         end
         if (!byte_sel_n[0])
         begin
            ctrl[7:0] <= data_in[7:0]; // odd byte
         end
      end
   end

   // unused scan codes count as disabled
   always_comb
   begin
      next_scan_on = 1'b0;
      if ((ctrl[ADCSC_SCAN_LSB+:3] != ADCSC_SCAN_OFF)
          && (ctrl[ADCSC_SCAN_LSB+:3] <= ADCSC_SCAN_EXT_ONLY))
      begin
         next_scan_on = 1'b1;
      end
   end

   // registered control decode, outputs lag the register by one clock
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         fmt_offset   <= 1'b0;
         trig_oe      <= 1'b0;
         source_sel   <= ADCSC_SRC_DIFF;
         source_diff  <= 1'b1; // cleared source code means differential
         source_calib <= 1'b0;
         scan_mode    <= ADCSC_SCAN_OFF;
         scan_active  <= 1'b0;
         timer_run    <= 1'b0;
         irq_each     <= 1'b0;
         irq_group    <= 1'b0;
      end
      else
      begin
         fmt_offset   <= ctrl[ADCSC_FMT_BIT];
         trig_oe      <= ctrl[ADCSC_TRIG_BIT];
         source_sel   <= ctrl[ADCSC_SRC_LSB+:3];
         source_diff  <= (ctrl[ADCSC_SRC_LSB+:3] == ADCSC_SRC_DIFF);
         source_calib <= (ctrl[ADCSC_SRC_LSB+:3] > ADCSC_SRC_UNUSED);
         scan_mode    <= next_scan_on ? ctrl[ADCSC_SCAN_LSB+:3] : ADCSC_SCAN_OFF;
         scan_active  <= next_scan_on;
         timer_run    <= ctrl[ADCSC_TIMER_BIT];
         irq_each     <= (ctrl[ADCSC_IRQ_LSB+:2] == ADCSC_IRQ_EACH);
         irq_group    <= (ctrl[ADCSC_IRQ_LSB+:2] == ADCSC_IRQ_GROUP);
      end
   end

   // trigger pin synchroniser; the edge detect looks at the second and third stages only
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         trig_meta <= 1'b0;
         trig_sync <= 1'b0;
         trig_prev <= 1'b0;
      end
      else
      begin
         trig_meta <= trig_in;
         trig_sync <= trig_meta;
         trig_prev <= trig_sync;
      end
   end

   // trigger source: own timer when driving, pin edge when receiving
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         trig_out   <= 1'b0;
         conv_start <= 1'b0;
      end
      else
      begin
         trig_out   <= timer_tick && timer_run && trig_oe;
         conv_start <= scan_active
                    && ((trig_oe ? (timer_tick && timer_run) : 1'b0)
                     || (!trig_oe && trig_sync && !trig_prev));
      end
   end

   // result coding before storage
   adcsc_fmt #(
      .WIDTH (DATA_W)
   ) u_fmt (
      .raw    (conv_raw),
      .offset (fmt_offset),
      .coded  (coded)
   );

   // hold each result one cycle so reads can see a store in progress
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         wr_pending <= 1'b0;
         wr_chan    <= 5'h00;
         wr_data    <= 16'h0000;
      end
      else
      begin
         wr_pending <= conv_valid;
         if (conv_valid)
         begin
            wr_chan <= conv_chan;
            wr_data <= coded;
         end
      end
   end

   // mailbox store; differential keeps the older sample sixteen entries up
   always_ff @(posedge clk)
   begin
      if (!rstn)
      begin
         for (int i = 0; i < ADCSC_CHANNELS; i++)
         begin
            mbox[i] <= 16'h0000;
         end
      end
      else if (wr_pending)
      begin
         if (source_diff)
         begin
            mbox[{1'b0, wr_chan[3:0]}] <= wr_data;
            mbox[{1'b1, wr_chan[3:0]}] <= mbox[{1'b0, wr_chan[3:0]}];
         end
         else
         begin
            mbox[wr_chan] <= wr_data;
         end
      end
   end
endmodule : adcsc_top
`default_nettype wire

// File: shared/adcsc_pkg.sv
`default_nettype none
package adcsc_pkg;
   // word addresses on bus lines a6..a1
   localparam logic [5:0] ADCSC_CTRL_WADDR    = 6'h00;
   localparam logic [5:0] ADCSC_RSVD_LO_WADDR = 6'h01; // registers kept outside this block
   localparam logic [5:0] ADCSC_RSVD_HI_WADDR = 6'h08;
   localparam logic [5:0] ADCSC_GAIN_LO_WADDR = 6'h10;
   localparam logic [5:0] ADCSC_GAIN_HI_WADDR = 6'h1f;
   localparam logic [5:0] ADCSC_MBOX_LO_WADDR = 6'h20;
   // control register reset value and field positions
   localparam logic [15:0] ADCSC_CTRL_RESET = 16'h0000;
   localparam int ADCSC_FMT_BIT    = 1;
   localparam int ADCSC_TRIG_BIT   = 2;
   localparam int ADCSC_SRC_LSB    = 3;
   localparam int ADCSC_SCAN_LSB   = 8;
   localparam int ADCSC_TIMER_BIT  = 11;
   localparam int ADCSC_IRQ_LSB    = 12;
   // input source codes
   localparam logic [2:0] ADCSC_SRC_DIFF   = 3'h0;
   localparam logic [2:0] ADCSC_SRC_SINGLE = 3'h1;
   localparam logic [2:0] ADCSC_SRC_UNUSED = 3'h2;
   // scan mode codes
   localparam logic [2:0] ADCSC_SCAN_OFF      = 3'h0;
   localparam logic [2:0] ADCSC_SCAN_EXT_ONLY = 3'h5;
   // interrupt policy codes
   localparam logic [1:0] ADCSC_IRQ_EACH  = 2'h1;
   localparam logic [1:0] ADCSC_IRQ_GROUP = 2'h2;
   // bus timing in clock cycles
   localparam logic [2:0] ADCSC_WAIT_STATES     = 3'h1;
   localparam logic [2:0] ADCSC_MAX_WAIT_STATES = 3'h6;
   // mailbox geometry
   localparam int ADCSC_CHANNELS  = 32;
   localparam int ADCSC_DIFF_CHAN = 16;
   // bus cycle states
   typedef enum logic [3:0] {
      ADCSC_IDLE = 4'b0001,
      ADCSC_WAIT = 4'b0010,
      ADCSC_ACK  = 4'b0100,
      ADCSC_HOLD = 4'b1000
   } adcsc_bus_t;
endpackage : adcsc_pkg
`default_nettype wire

// File: test/adcsc_checker.sv
`timescale 1ns/100ps
`default_nettype none
module adcsc_checker
(
   // clock and reset
   input wire logic       clk,
   input wire logic       rstn,
   // host bus
   input wire logic       io_sel_n,
   input wire logic [5:0] addr,
   input wire logic       data_oe,
   input wire logic       ack_n,
   // trigger and timer
   input wire logic       timer_tick,
   input wire logic       timer_run,
   input wire logic       trig_oe,
   input wire logic       trig_out,
   // decoded control
   input wire logic [2:0] source_sel,
   input wire logic       source_diff,
   input wire logic       source_calib,
   input wire logic [2:0] scan_mode,
   input wire logic       scan_active,
   input wire logic       irq_each,
   input wire logic       irq_group,
   input wire logic       fmt_offset,
   input wire logic       conv_start
);
   logic drive_tick;

   default clocking cb @(posedge clk); endclocking
   default disable iff (!rstn);

   // tick that should reach the trigger pin
   assign drive_tick = timer_tick & timer_run & trig_oe;

   unmapped_silent_a: assert property (
      !io_sel_n && addr >= 6'h09 && addr <= 6'h0f |-> ack_n && !data_oe)
      else $error("answer on unmapped address");
   one_wait_a: assert property (
      $fell(io_sel_n) && addr < 6'h09 |-> ack_n ##1 ack_n ##1 !ack_n)
      else $error("register access not one wait state");
   mbox_wait_a: assert property (
      $fell(io_sel_n) && addr[5] |-> ##[2:7] !ack_n)
      else $error("mailbox read over six wait states");
   ack_pulse_a: assert property (!ack_n |=> ack_n)
      else $error("ack longer than one cycle");
   oe_hold_a: assert property (data_oe |-> !$past(io_sel_n))
      else $error("read drive without select");
   reset_clear_a: assert property (disable iff (1'b0)
      !rstn |=> !fmt_offset && !trig_oe && !timer_run && !scan_active && !irq_each
      && !irq_group && ack_n && !data_oe)
      else $error("reset left control active");
   scan_code_a: assert property (
      scan_active == (scan_mode != 3'h0) && scan_mode <= 3'h5)
      else $error("bad scan decode");
   source_code_a: assert property (
      source_diff == (source_sel == 3'h0) && source_calib == (source_sel >= 3'h3))
      else $error("bad source decode");
   irq_excl_a: assert property (!(irq_each && irq_group))
      else $error("two interrupt policies at once");
   trig_echo_a: assert property (trig_out == $past(drive_tick))
      else $error("trigger output not the gated tick");
   start_gate_a: assert property (conv_start |-> $past(scan_active))
      else $error("conversion started with scan off");
endmodule : adcsc_checker

bind adcsc_top adcsc_checker u_chk (.clk, .rstn, .io_sel_n, .addr, .data_oe, .ack_n,
   .timer_tick, .timer_run, .trig_oe, .trig_out, .source_sel, .source_diff, .source_calib,
   .scan_mode, .scan_active, .irq_each, .irq_group, .fmt_offset, .conv_start);
`default_nettype wire

// File: test/adcsc_host.sv
`timescale 1ns/100ps
`default_nettype none
module adcsc_host
(
   // clock
   input wire logic         clk,
   // answer from the device
   input wire logic [15:0]  data_out,
   input wire logic         ack_n,
   // request towards the device
   output logic             io_sel_n,
   output logic             write_n,
   output logic [5:0]       addr,
   output logic [1:0]       byte_sel_n,
   output logic [15:0]      data_in
);
   // idle bus at time zero
   initial
   begin
      io_sel_n = 1'b1;
      write_n = 1'b1;
      addr = 6'h00;
      byte_sel_n = 2'h3;
      data_in = 16'h0000;
   end

   // one cycle, held until ack is sampled; gives up after 12 edges
   task access(input logic wr, input logic [5:0] a, input logic [1:0] be_n,
         input logic [15:0] d, output logic [15:0] q, output logic acked);
      @(negedge clk);
      io_sel_n = 1'b0;
      write_n = ~wr;
      addr = a;
      byte_sel_n = be_n;
      data_in = d;
      acked = 1'b0;
      q = 16'h0000;
      for (int n = 0; n < 12 && !acked; n++)
      begin
         @(posedge clk);
         if (ack_n === 1'b0)
         begin
            acked = 1'b1;
            q = data_out;
         end
      end
      // released lines carry junk, nothing keeps them
      @(negedge clk);
      io_sel_n = 1'b1;
      addr = ~a;
      byte_sel_n = ~be_n;
      data_in = ~d;
      repeat (2) @(negedge clk);
   endtask : access
endmodule : adcsc_host
`default_nettype wire

// File: test/test_adcsc_top.sv
`timescale 1ns/100ps
`default_nettype none
module test_adcsc_top;
   logic        clk = 1'b0;
   logic        rstn = 1'b0;
   logic        conv_valid = 1'b0;
   logic        trig_in = 1'b0;
   logic        timer_tick = 1'b0;
   logic [4:0]  conv_chan = 5'h00;
   logic [15:0] conv_raw = 16'h0000;
   logic        io_sel_n, write_n, data_oe, ack_n, trig_out, trig_oe, fmt_offset;
   logic        source_diff, source_calib, scan_active, timer_run, irq_each, irq_group;
   logic        conv_start, acked;
   logic [5:0]  addr;
   logic [1:0]  byte_sel_n;
   logic [2:0]  source_sel, scan_mode;
   logic [15:0] data_in, data_out, q, c, v, dec;
   logic [15:0] codes [4] = '{16'h7fff, 16'h0000, 16'hffff, 16'h8000};
   int          errors = 0;
   int          tests_run = 0;
   int          starts = 0;

   always #2 clk = ~clk;

   // count conversion starts
   always @(posedge clk)
      if (conv_start === 1'b1)
         starts <= starts + 1;

   // decoded outputs packed for one compare
   assign dec = {1'b0, trig_oe, irq_group, irq_each, timer_run, scan_active, scan_mode,
      source_calib, source_diff, source_sel, fmt_offset, 1'b0};

   adcsc_host u_host (.clk, .data_out, .ack_n, .io_sel_n, .write_n, .addr, .byte_sel_n,
      .data_in);
   adcsc_top u_dut (.clk, .rstn, .io_sel_n, .write_n, .addr, .byte_sel_n, .data_in,
      .data_out, .data_oe, .ack_n, .conv_valid, .conv_chan, .conv_raw, .trig_in, .trig_out,
      .trig_oe, .timer_tick, .fmt_offset, .source_sel, .source_diff, .source_calib,
      .scan_mode, .scan_active, .timer_run, .irq_each, .irq_group, .conv_start);

   function automatic logic [15:0] exp_dec(input logic [15:0] w);
      logic [2:0] s;
      s = (w[10:8] > 3'h5) ? 3'h0 : w[10:8];
      return {1'b0, w[2], w[13:12] == 2'h2, w[13:12] == 2'h1, w[11], s != 3'h0, s,
         w[5:3] >= 3'h3, w[5:3] == 3'h0, w[5:3], w[1], 1'b0};
   endfunction : exp_dec

   task chk(input logic [15:0] got, input logic [15:0] exp);
      tests_run++;
      if (got !== exp)
      begin
         errors++;
         $display("CHECK FAILED %0t got %h exp %h", $time, got, exp);
      end
   endtask : chk

   task wr(input logic [5:0] a, input logic [1:0] be_n, input logic [15:0] d);
      u_host.access(1'b1, a, be_n, d, q, acked);
      chk({15'h0000, acked}, 16'h0001);
   endtask : wr

   task rd(input logic [5:0] a, input logic [15:0] exp);
      u_host.access(1'b0, a, 2'b00, 16'h0000, q, acked);
      chk({15'h0000, acked}, 16'h0001);
      chk(q, exp);
   endtask : rd

   // one result from the sequencer, then let it settle
   task store(input logic [4:0] ch, input logic [15:0] raw);
      @(negedge clk);
      conv_valid = 1'b1;
      conv_chan = ch;
      conv_raw = raw;
      @(negedge clk);
      conv_valid = 1'b0;
      conv_raw = ~raw;
      repeat (2) @(negedge clk);
   endtask : store

   task final_report;
      $display("errors %0d tests_run %0d", errors, tests_run);
      if (errors == 0 && tests_run > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask : final_report

   // watchdog, far beyond the roughly 1.4 microseconds the run needs
   initial
   begin
      #20000;
      errors++;
      final_report();
   end

   initial
   begin
      repeat (6) @(negedge clk);
      rstn = 1'b1;
      rd(6'h00, 16'h0000);
      chk(dec, 16'h0020);
      for (int i = 0; i < 8; i++)
      begin
         c = {2'b10, i[1:0], i[0], i[2:0], 2'b01, i[2:0], i[1], i[2], 1'b1};
         wr(6'h00, 2'b00, c);
         rd(6'h00, c);
         chk(dec, exp_dec(c));
      end
      wr(6'h00, 2'b01, 16'ha500);
      rd(6'h00, 16'ha57f);
      wr(6'h00, 2'b10, 16'h003c);
      rd(6'h00, 16'ha53c);
      u_host.access(1'b0, 6'h0b, 2'b00, 16'h0000, q, acked);
      chk({15'h0000, acked}, 16'h0000);
      for (int f = 1; f >= 0; f--)
      begin
         wr(6'h00, 2'b00, f ? 16'h000a : 16'h0008);
         for (int j = 0; j < 4; j++)
         begin
            v = codes[j];
            store(5'(j + 4 * f), v);
            rd(6'(32 + j + 4 * f), f ? v ^ 16'h8000 : v);
         end
      end
      rd(6'h30, 16'h0000);
      wr(6'h00, 2'b00, 16'h0000);
      store(5'h05, 16'h1234);
      store(5'h05, 16'h4321);
      rd(6'h25, 16'h4321);
      rd(6'h35, 16'h1234);
      // a read that meets a store in progress waits and then sees the new word
      fork
         store(5'h06, 16'h5a5a);
         rd(6'h26, 16'h5a5a);
      join
      wr(6'h00, 2'b00, 16'h0904);
      @(negedge clk);
      timer_tick = 1'b1;
      @(negedge clk);
      timer_tick = 1'b0;
      repeat (4) @(negedge clk);
      chk(starts[15:0], 16'h0001);
      foreach (codes[k])
      begin
         wr(6'h00, 2'b00, k[0] ? 16'h0600 : 16'h0100);
         trig_in = 1'b1;
         repeat (6) @(negedge clk);
         trig_in = 1'b0;
         chk(starts[15:0], 16'(2 + k / 2));
      end
      rstn = 1'b0;
      repeat (2) @(negedge clk);
      rstn = 1'b1;
      rd(6'h00, 16'h0000);
      final_report();
   end
endmodule : test_adcsc_top
`default_nettype wire
